// file: hw/vgc_pkg.sv
/*
  Shared constants and carrier types for the per-port configuration register bank.
  Assumes one board clock and a host write strobe that is already synchronous to it.
*/
`default_nettype none

package vgc_pkg;

  // Register offsets within the port address window.
  localparam int unsigned ADDR_W = 10;
  localparam logic [ADDR_W-1:0] OFF_CFG1_A = 10'h101;
  localparam logic [ADDR_W-1:0] OFF_CFG1_B = 10'h301;
  localparam logic [ADDR_W-1:0] OFF_CFG2_A = 10'h105;
  localparam logic [ADDR_W-1:0] OFF_CFG2_B = 10'h305;

  // Field positions of configuration register one.
  localparam int unsigned C1_IRQ_LSB = 5;
  localparam int unsigned C1_IRQ_MSB = 7;
  localparam int unsigned C1_BRG_LSB = 3;
  localparam int unsigned C1_BRG_MSB = 4;
  localparam int unsigned C1_CC_BIT  = 2;
  localparam int unsigned C1_ROR_BIT = 1;
  localparam int unsigned C1_DIR_BIT = 0;

  // Field positions of configuration register two.
  localparam int unsigned C2_EXT_BIT = 4;
  localparam int unsigned C2_SFL_BIT = 3;
  localparam int unsigned C2_SUP_BIT = 2;
  localparam int unsigned C2_LMR_BIT = 1;
  localparam int unsigned C2_SC_BIT  = 0;

  // Reset values.
  localparam logic [2:0] RST_IRQ = 3'h0;
  localparam logic [1:0] RST_BRG = 2'h0;
  localparam logic       RST_CC  = 1'h0;
  localparam logic       RST_ROR = 1'h1;
  localparam logic       RST_DIR = 1'h0;
  localparam logic       RST_EXT = 1'h0;
  localparam logic       RST_SFL = 1'h0;
  localparam logic       RST_SUP = 1'h0;
  localparam logic       RST_SC  = 1'h0;

  // Number of ports, interrupt lines and request/grant levels.
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned NUM_IRQ   = 7;
  localparam int unsigned NUM_BRG   = 4;

  // Host write request.
  typedef struct packed {
    logic              stb;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } vgc_wr_req_t;

  // Board-wide settings.
  typedef struct packed {
    logic [2:0] irq_line_select;
    logic [1:0] bus_req_grant_level;
    logic       release_on_request_off;
    logic       extended_addressing_enable;
    logic       system_fail_drive;
  } vgc_board_cfg_t;

  // Settings held separately for each port.
  typedef struct packed {
    logic carry_cycle_enable;
    logic xfer_dir;
    logic access_mode_select;
    logic system_controller_role;
  } vgc_port_cfg_t;

endpackage : vgc_pkg

`default_nettype wire

// file: hw/vgc_config_regs.sv
/*
  Write-only configuration register bank for both ports of the board: interrupt line,
  bus request/grant level, carry cycle, release on request, direction and the second
  register's mode bits, plus the local master reset. Assumes the host write request
  arrives as a one-cycle strobe synchronous to SYS_CLK with address and data valid.
*/
// Behaviour
// - Interrupt codes 110 and 111 select lines 6 and 7; reset selects none.
// - Interrupt field bits 7..5: 000 none, 001..101 select lines 1..5.
// - Bits 4..3 pick request/grant level 0..3.
// - Request/grant level resets to 0.
// - Request/grant level is shared by both ports.
// - Bit 2 enables carry cycle; disabled after reset.
// - Carry cycle enable is stored per port.
// - Bit 1 high disables release on request, board-wide.
// - Release-on-request control resets to 1.
// - Bit 0 is direction: 0 memory to instrument bus, 1 reverse.
// - Direction is stored independently per port.
// - Direction resets to 0.
// - Second register decodes at 105 and 305 hex, write only.
// - Second register holds extended, fail drive, mode, master reset, controller bits.
// - Writing the master reset bit returns the board to a known state.
// - First register decodes at 101 and 301 hex, write only.
// - Board-wide bits have one storage element written from either port.
// - One interrupt line selection serves both ports.
`timescale 1ns/1ps
`default_nettype none

module vgc_config_regs (
  input  wire logic                                      SYS_CLK,
  input  wire logic                                      SYS_RST,
  input  wire vgc_pkg::vgc_wr_req_t                      WR_REQ,
  output var  vgc_pkg::vgc_board_cfg_t                   BOARD_CFG,
  output var  vgc_pkg::vgc_port_cfg_t [vgc_pkg::NUM_PORTS-1:0] PORT_CFG,
  output logic [vgc_pkg::NUM_IRQ-1:0]                    IRQ_LINE_ONEHOT,
  output logic [vgc_pkg::NUM_BRG-1:0]                    BRG_LEVEL_ONEHOT,
  output logic                                           LOCAL_MASTER_RESET
);

  // Address decode of the four write-only registers; all other offsets are ignored.
  logic [vgc_pkg::NUM_PORTS-1:0] hit_c1;
  logic [vgc_pkg::NUM_PORTS-1:0] hit_c2;
  logic                          any_c1;
  logic                          any_c2;
  logic                          lmr_hit;
  assign hit_c1[0] = WR_REQ.stb && (WR_REQ.addr == vgc_pkg::OFF_CFG1_A);
  assign hit_c1[1] = WR_REQ.stb && (WR_REQ.addr == vgc_pkg::OFF_CFG1_B);
  assign hit_c2[0] = WR_REQ.stb && (WR_REQ.addr == vgc_pkg::OFF_CFG2_A);
  assign hit_c2[1] = WR_REQ.stb && (WR_REQ.addr == vgc_pkg::OFF_CFG2_B);
  assign any_c1    = |hit_c1;
  assign any_c2    = |hit_c2;
  assign lmr_hit   = any_c2 && WR_REQ.data[vgc_pkg::C2_LMR_BIT];

  // Board-wide storage, one flip-flop per bit whichever port writes it.
  logic [2:0] irq_r;
  logic [2:0] irq_nxt;
  logic [1:0] brg_r;
  logic [1:0] brg_nxt;
  logic       ror_r;
  logic       ror_nxt;
  logic       ext_r;
  logic       ext_nxt;
  logic       sfl_r;
  logic       sfl_nxt;
  logic       lmr_r;

  // Next values; a master reset write forces defaults except the fail drive bit.
  assign irq_nxt = lmr_hit ? vgc_pkg::RST_IRQ :
                   any_c1  ? WR_REQ.data[vgc_pkg::C1_IRQ_MSB:vgc_pkg::C1_IRQ_LSB] : irq_r;
  assign brg_nxt = lmr_hit ? vgc_pkg::RST_BRG :
                   any_c1  ? WR_REQ.data[vgc_pkg::C1_BRG_MSB:vgc_pkg::C1_BRG_LSB] : brg_r;
  assign ror_nxt = lmr_hit ? vgc_pkg::RST_ROR :
                   any_c1  ? WR_REQ.data[vgc_pkg::C1_ROR_BIT] : ror_r;
  assign ext_nxt = lmr_hit ? vgc_pkg::RST_EXT :
                   any_c2  ? WR_REQ.data[vgc_pkg::C2_EXT_BIT] : ext_r;
  assign sfl_nxt = any_c2  ? WR_REQ.data[vgc_pkg::C2_SFL_BIT] : sfl_r;

  // Board-wide registers with their power-up values.
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      irq_r <= vgc_pkg::RST_IRQ;
      brg_r <= vgc_pkg::RST_BRG;
      ror_r <= vgc_pkg::RST_ROR;
      ext_r <= vgc_pkg::RST_EXT;
      sfl_r <= vgc_pkg::RST_SFL;
      lmr_r <= 1'h0;
    end else begin
      irq_r <= irq_nxt;
      brg_r <= brg_nxt;
      ror_r <= ror_nxt;
      ext_r <= ext_nxt;
      sfl_r <= sfl_nxt;
      lmr_r <= lmr_hit;
    end
  end

  // Per-port storage; each port responds to its own register offsets, and a master reset write from either port clears both.
  logic [vgc_pkg::NUM_PORTS-1:0] cc_r;
  logic [vgc_pkg::NUM_PORTS-1:0] dir_r;
  logic [vgc_pkg::NUM_PORTS-1:0] sup_r;
  logic [vgc_pkg::NUM_PORTS-1:0] sc_r;
  logic [vgc_pkg::NUM_PORTS-1:0] cc_nxt;
  logic [vgc_pkg::NUM_PORTS-1:0] dir_nxt;
  logic [vgc_pkg::NUM_PORTS-1:0] sup_nxt;
  logic [vgc_pkg::NUM_PORTS-1:0] sc_nxt;

  for (genvar p = 0; p < vgc_pkg::NUM_PORTS; p++) begin : g_port
    // Next values; bits 7..5 of the second register have no storage at all.
    assign cc_nxt[p]  = lmr_hit   ? vgc_pkg::RST_CC :
                        hit_c1[p] ? WR_REQ.data[vgc_pkg::C1_CC_BIT] : cc_r[p];
    assign dir_nxt[p] = lmr_hit   ? vgc_pkg::RST_DIR :
                        hit_c1[p] ? WR_REQ.data[vgc_pkg::C1_DIR_BIT] : dir_r[p];
    assign sup_nxt[p] = lmr_hit   ? vgc_pkg::RST_SUP :
                        hit_c2[p] ? WR_REQ.data[vgc_pkg::C2_SUP_BIT] : sup_r[p];
    assign sc_nxt[p]  = lmr_hit   ? vgc_pkg::RST_SC :
                        hit_c2[p] ? WR_REQ.data[vgc_pkg::C2_SC_BIT] : sc_r[p];

    // Port registers with their power-up values.
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
        cc_r[p]  <= vgc_pkg::RST_CC;
        dir_r[p] <= vgc_pkg::RST_DIR;
        sup_r[p] <= vgc_pkg::RST_SUP;
        sc_r[p]  <= vgc_pkg::RST_SC;
      end else begin
        cc_r[p]  <= cc_nxt[p];
        dir_r[p] <= dir_nxt[p];
        sup_r[p] <= sup_nxt[p];
        sc_r[p]  <= sc_nxt[p];
      end
    end

    // Port view of the stored settings.
    assign PORT_CFG[p].carry_cycle_enable     = cc_r[p];
    assign PORT_CFG[p].xfer_dir               = dir_r[p];
    assign PORT_CFG[p].access_mode_select     = sup_r[p];
    assign PORT_CFG[p].system_controller_role = sc_r[p];
  end

  // One-hot decode of the interrupt line; code 0 drives no line.
  for (genvar i = 0; i < vgc_pkg::NUM_IRQ; i++) begin : g_irq
    assign IRQ_LINE_ONEHOT[i] = (irq_r == 3'(i + 1));
  end

  // One-hot decode of the request/grant pair shared by both ports.
  for (genvar j = 0; j < vgc_pkg::NUM_BRG; j++) begin : g_brg
    assign BRG_LEVEL_ONEHOT[j] = (brg_r == 2'(j));
  end

  // Board-wide view and the one-cycle local reset pulse.
  assign BOARD_CFG.irq_line_select            = irq_r;
  assign BOARD_CFG.bus_req_grant_level        = brg_r;
  assign BOARD_CFG.release_on_request_off     = ror_r;
  assign BOARD_CFG.extended_addressing_enable = ext_r;
  assign BOARD_CFG.system_fail_drive          = sfl_r;
  assign LOCAL_MASTER_RESET                   = lmr_r;

  // Checks on the stored settings against the writes that caused them.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  chk_reset_values: assert property ($fell(SYS_RST) |-> irq_r == 3'h0 && brg_r == 2'h0 && ror_r == 1'h1
      && cc_r == 2'h0 && dir_r == 2'h0)
    else $error("Configuration not at power-up values after reset.");
  chk_irq_high_codes: assert property (irq_r == 3'h6 |-> IRQ_LINE_ONEHOT == 7'h20)
    else $error("Interrupt code 6 does not select line 6.");
  chk_irq_low_codes: assert property ((irq_r == 3'h0 |-> IRQ_LINE_ONEHOT == 7'h00)
      and (irq_r == 3'h5 |-> IRQ_LINE_ONEHOT == 7'h10))
    else $error("Interrupt code decode wrong for codes 0 or 5.");
  chk_brg_shared: assert property (any_c1 && !lmr_hit |=>
      brg_r == $past(WR_REQ.data[4:3]) && irq_r == $past(WR_REQ.data[7:5]) && ror_r == $past(WR_REQ.data[1]))
    else $error("Board-wide field not taken from a register one write.");
  chk_cc_per_port: assert property (hit_c1[0] |=> cc_r[0] == $past(WR_REQ.data[2]) && $stable(cc_r[1]))
    else $error("Carry cycle bit not held per port.");
  chk_dir_per_port: assert property (hit_c1[1] |=> dir_r[1] == $past(WR_REQ.data[0]) && $stable(dir_r[0]))
    else $error("Direction bit not held per port.");
  chk_no_stray_write: assert property (!any_c1 && !any_c2 |=> $stable(irq_r) && $stable(brg_r) && $stable(cc_r)
      && $stable(dir_r) && $stable(sfl_r) && !lmr_r)
    else $error("Setting changed without a decoded write.");
  chk_cfg2_fields: assert property (hit_c2[1] && !lmr_hit |=> sc_r[1] == $past(WR_REQ.data[0])
      && sup_r[1] == $past(WR_REQ.data[2]) && ext_r == $past(WR_REQ.data[4]) && $stable(sc_r[0]))
    else $error("Second register fields not stored as written.");
  chk_master_reset: assert property (lmr_hit |=> LOCAL_MASTER_RESET && irq_r == 3'h0 && ror_r == 1'h1
      && cc_r == 2'h0 && sfl_r == $past(WR_REQ.data[3]) ##1 (LOCAL_MASTER_RESET == $past(lmr_hit)))
    else $error("Master reset did not restore defaults for one pulse.");

  // The remaining checks cover the other port of each per-port bit, the fields that the
  // checks above leave out, and the isolation between the two registers of a port.
  // A write to one register, other than a master reset write, must never disturb the settings that the other one holds,
  // because the host cannot read anything back to notice the damage.

  // The request/grant decode always drives exactly one level.
  chk_brg_onehot: assert property ($onehot(BRG_LEVEL_ONEHOT))
    else $error("Request/grant level decode is not one-hot.");

  // The request/grant decode follows the stored level.
  chk_brg_decode: assert property (BRG_LEVEL_ONEHOT == (4'h1 << brg_r))
    else $error("Request/grant level decode does not follow the stored level.");

  // The interrupt decode drives at most one line.
  chk_irq_onehot0: assert property ($onehot0(IRQ_LINE_ONEHOT))
    else $error("More than one interrupt line selected.");

  // Code 7 selects the top interrupt line.
  chk_irq_seven: assert property (irq_r == 3'h7 |-> IRQ_LINE_ONEHOT == 7'h40)
    else $error("Interrupt code 7 does not select line 7.");

  // Port A's register one sets the shared fields just like port B's.
  chk_irq_port_a: assert property (hit_c1[0] |=>
      irq_r == $past(WR_REQ.data[7:5]) && brg_r == $past(WR_REQ.data[4:3]))
    else $error("Port A write did not set the shared fields.");

  // Release on request is one board-wide bit written from either port.
  chk_ror_port_a: assert property (hit_c1[0] |=> ror_r == $past(WR_REQ.data[1]))
    else $error("Release-on-request bit not taken from a port A write.");

  // Port B's carry cycle bit changes without touching port A's.
  chk_cc_port_b: assert property (hit_c1[1] |=> cc_r[1] == $past(WR_REQ.data[2]) && $stable(cc_r[0]))
    else $error("Port B carry cycle bit not held separately.");

  // Port A's direction bit changes without touching port B's.
  chk_dir_port_a: assert property (hit_c1[0] |=> dir_r[0] == $past(WR_REQ.data[0]) && $stable(dir_r[1]))
    else $error("Port A direction bit not held separately.");

  // Port A's second register stores its own mode bits only.
  chk_cfg2_port_a: assert property (hit_c2[0] && !lmr_hit |=> sc_r[0] == $past(WR_REQ.data[0])
      && sup_r[0] == $past(WR_REQ.data[2]) && $stable(sc_r[1]) && $stable(sup_r[1]))
    else $error("Port A second register fields not stored as written.");

  // The shared bits of the second register are one flip-flop for both ports.
  chk_ext_board_wide: assert property (hit_c2[0] && !lmr_hit |=> ext_r == $past(WR_REQ.data[4])
      && sfl_r == $past(WR_REQ.data[3]))
    else $error("Shared second register bits not taken from a port A write.");

  // A plain second register write leaves register one's settings alone.
  chk_cfg2_keeps_cfg1: assert property (any_c2 && !lmr_hit |=> $stable(irq_r) && $stable(brg_r)
      && $stable(ror_r) && $stable(cc_r) && $stable(dir_r) && !LOCAL_MASTER_RESET)
    else $error("Second register write disturbed register one settings.");

  // A register one write leaves the second register's settings alone.
  chk_cfg1_keeps_cfg2: assert property (any_c1 |=> $stable(ext_r) && $stable(sfl_r)
      && $stable(sup_r) && $stable(sc_r) && !LOCAL_MASTER_RESET)
    else $error("Register one write disturbed second register settings.");

  // A master reset returns every other field to its default while the fail drive bit takes the write.
  chk_lmr_clears_rest: assert property (lmr_hit |=> ext_r == 1'h0 && brg_r == 2'h0
      && dir_r == 2'h0 && sup_r == 2'h0 && sc_r == 2'h0)
    else $error("Master reset left a setting away from its default.");

  // The local reset pulse only ever follows a decoded master reset write.
  chk_lmr_pulse_source: assert property (LOCAL_MASTER_RESET |-> $past(lmr_hit))
    else $error("Local reset pulse without a master reset write.");

  // The rest of the settings also leave reset at their defaults.
  chk_reset_rest: assert property ($fell(SYS_RST) |-> ext_r == 1'h0 && sfl_r == 1'h0
      && sup_r == 2'h0 && sc_r == 2'h0 && !LOCAL_MASTER_RESET)
    else $error("Second register settings not at power-up values after reset.");

  // The top request/grant level is reachable from port B.
  chk_brg_top_level: assert property (hit_c1[1] && WR_REQ.data[4:3] == 2'h3 |=> BRG_LEVEL_ONEHOT == 4'h8)
    else $error("Request/grant code 3 does not select level 3.");

  cov_port_a_cfg1: cover property (hit_c1[0] ##1 hit_c1[1]);
  cov_opposite_dir: cover property (dir_r == 2'h1);
  cov_irq_seven: cover property (irq_r == 3'h7);
  cov_master_reset: cover property (hit_c2[0] && lmr_hit);
  cov_port_b_cfg2: cover property (hit_c2[1] && !lmr_hit ##1 hit_c2[0]);

endmodule // vgc_config_regs

`default_nettype wire

// file: verification/vgc_host_model.sv
/*
  Host-side model that writes the configuration bank.
  Assumes the caller invokes wr in the time step of a rising edge of the board clock.
*/
`timescale 1ns/1ps
`default_nettype none

module vgc_host_model (
  output var vgc_pkg::vgc_wr_req_t WR_REQ
);
  // The bus starts idle before the first request.
  initial WR_REQ = '0;

  // One whole byte per call; an idle bus shows inverted values so stale data never looks valid.
  task automatic wr(input logic s, input logic [9:0] a, input logic [7:0] d);
    WR_REQ <= s ? {1'b1, a, d} : {1'b0, ~a, ~d};
  endtask
endmodule // vgc_host_model

`default_nettype wire

// file: verification/vgc_config_regs_tb.sv
/*
  Self-checking testbench for the configuration register bank.
  Assumes the host model and the package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module vgc_config_regs_tb;
  logic                         SYS_CLK;
  logic                         SYS_RST;
  vgc_pkg::vgc_wr_req_t         WR_REQ;
  vgc_pkg::vgc_board_cfg_t      BOARD_CFG, eb;
  vgc_pkg::vgc_port_cfg_t [1:0] PORT_CFG, ep;
  logic [6:0]                   IRQ_LINE_ONEHOT;
  logic [3:0]                   BRG_LEVEL_ONEHOT;
  logic                         LOCAL_MASTER_RESET, el;
  logic [18:0]                  pend;
  logic [31:0]                  seed, r;
  int                           miscompares, check_count;
  logic [9:0]                   addrs [6] = '{10'h101, 10'h301, 10'h105, 10'h305, 10'h103, 10'h201};

  vgc_config_regs i_vgc_config_regs (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .WR_REQ(WR_REQ),
    .BOARD_CFG(BOARD_CFG), .PORT_CFG(PORT_CFG), .IRQ_LINE_ONEHOT(IRQ_LINE_ONEHOT),
    .BRG_LEVEL_ONEHOT(BRG_LEVEL_ONEHOT), .LOCAL_MASTER_RESET(LOCAL_MASTER_RESET));
  vgc_host_model i_vgc_host_model (.WR_REQ(WR_REQ));

  // The board clock runs at 100 MHz.
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // Random source, a 32-bit xorshift.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected one-hot interrupt line, all zero for code 0.
  function automatic logic [6:0] irq_hot(input logic [2:0] c);
    return (c == 3'h0) ? 7'h00 : 7'h01 << (c - 3'h1);
  endfunction

  // Expected state after a power-up or local reset.
  function automatic void reset_exp();
    eb = '{vgc_pkg::RST_IRQ, vgc_pkg::RST_BRG, vgc_pkg::RST_ROR, vgc_pkg::RST_EXT, vgc_pkg::RST_SFL};
    for (int i = 0; i < 2; i++) ep[i] = '{vgc_pkg::RST_CC, vgc_pkg::RST_DIR, vgc_pkg::RST_SUP, vgc_pkg::RST_SC};
    el = 1'b0;
  endfunction

  // Folds one request into the expected state.
  function automatic void apply(input logic [18:0] q);
    logic [9:0] a;
    logic [7:0] d;
    logic       p;
    a = q[17:8];
    d = q[7:0];
    p = a[9];
    el = 1'b0;
    if (!q[18]) return;
    if (a == 10'h101 || a == 10'h301) begin
      eb.irq_line_select = d[7:5];
      eb.bus_req_grant_level = d[4:3];
      eb.release_on_request_off = d[1];
      ep[p].carry_cycle_enable = d[2];
      ep[p].xfer_dir = d[0];
    end else if (a == 10'h105 || a == 10'h305) begin
      if (d[1]) begin
        reset_exp();
        el = 1'b1;
      end else begin
        eb.extended_addressing_enable = d[4];
        ep[p].access_mode_select = d[2];
        ep[p].system_controller_role = d[0];
      end
      eb.system_fail_drive = d[3];
    end
  endfunction

  // Compares one result and reports a difference at once.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Issues a request on the edge, then checks the settled outputs at the falling edge.
  task automatic step(input logic s, input logic [9:0] a, input logic [7:0] d);
    i_vgc_host_model.wr(s, a, d);
    @(negedge SYS_CLK);
    apply(pend);
    cmp(BOARD_CFG, eb);
    cmp(PORT_CFG, ep);
    cmp(IRQ_LINE_ONEHOT, irq_hot(eb.irq_line_select));
    cmp(BRG_LEVEL_ONEHOT, 4'h1 << eb.bus_req_grant_level);
    cmp(LOCAL_MASTER_RESET, el);
    pend = {s, a, d};
    @(posedge SYS_CLK);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (2000) @(posedge SYS_CLK);
    miscompares++;
    summarize();
  end

  // Main sequence: reset, corner cases, then random back-to-back traffic.
  initial begin
    SYS_RST = 1'b1;
    seed = 32'h0000002A;
    pend = '0;
    reset_exp();
    repeat (12) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    for (int i = 0; i < 8; i++) step(1'b1, 10'h301, {i[2:0], i[1:0], 3'h2});
    step(1'b1, 10'h101, 8'hC5);
    step(1'b1, 10'h301, 8'h02);
    step(1'b1, 10'h105, 8'hFD);
    step(1'b1, 10'h305, 8'hEA);
    step(1'b1, 10'h103, 8'hFF);
    step(1'b1, 10'h201, 8'hFF);
    step(1'b0, 10'h101, 8'hFF);
    repeat (300) begin
      r = xs();
      step(r[3:0] != 4'h0, addrs[r[7:4] % 6], r[15:8] & ((r[19:16] == 4'h0) ? 8'hFF : 8'hFD));
    end
    step(1'b0, 10'h000, 8'h00);
    step(1'b0, 10'h000, 8'h00);
    summarize();
  end
endmodule // vgc_config_regs_tb

`default_nettype wire
